// >>> design/shbx_core.sv
// Execution of breakpoint, mask change, barriers, special moves and hints.
// Assumes the pipeline holds an instruction until instr_ready and memory reports idle.
//
// Summary of operation
// - Breakpoint requests debug entry, immediate ignored
// - Breakpoint executes even when condition fails
// - Mask set/clear forms update selected masks
// - Unprivileged mask change does nothing
// - Memory barrier holds later accesses until idle
// - Memory barrier never stalls non-memory instructions
// - Sync barrier stalls all until memory idle
// - Instruction barrier flushes pipeline when complete
// - Special-to-general move copies selected register
// - Conditional base-priority read returns base priority
// - Unprivileged special writes reach only application status
// - Unprivileged status writes drop exec/unallocated bits
// - Conditional base-priority write only raises priority
// - Status writes that include application status load flags from source
// - No-operation retires with no effect
// - Send event pulses out, sets event register
// - Supervisor call raises exception, immediate ignored
// - Wait-event sleeps until qualifying wake source
// - Wait-event with event set clears, continues
// - Wait-interrupt sleeps until exception or debug
// - Other instructions leave flags untouched
`default_nettype none
module shbx_core #(
  parameter int unsigned PRIO_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire shbx_pkg::shbx_instr_t instr,
  input wire logic privileged,
  input wire logic [8:0] exc_num,
  input wire logic exec_state,
  input wire logic mem_idle,
  input wire shbx_pkg::shbx_wake_t wake,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic instr_ready,
  output logic gpr_we,
  output logic [31:0] gpr_data,
  output logic flags_we,
  output logic [4:0] flags,
  output logic debug_enter,
  output logic svc_raise,
  output logic sev_out,
  output logic pipe_flush,
  output logic mem_hold,
  output logic sleeping,
  output logic interrupt_mask_bit,
  output logic fault_mask_bit,
  output logic [PRIO_W-1:0] base_priority_reg,
  output logic [1:0] control,
  output logic [31:0] main_sp,
  output logic [31:0] proc_sp
);
  import shbx_pkg::*;

  shbx_state_t state_r, state_nxt;
  logic [1:0] ctrl_r;
  logic event_r;
  logic fire;
  logic wfe_wake;
  logic wfi_wake;

  function automatic logic has_app(input shbx_sr_sel_t s);
    return s inside {SHBX_SR_APP, SHBX_SR_EXC_APP, SHBX_SR_EXEC_APP, SHBX_SR_ALL};
  endfunction

  function automatic logic is_status(input shbx_sr_sel_t s);
    return s inside {SHBX_SR_APP, SHBX_SR_EXC, SHBX_SR_EXEC, SHBX_SR_EXC_EXEC,
                     SHBX_SR_EXC_APP, SHBX_SR_EXEC_APP, SHBX_SR_ALL};
  endfunction

  // Breakpoint ignores the condition; everything else obeys it
  assign fire = instr.valid && instr_ready &&
                (instr.cond_pass || instr.op == SHBX_OP_BREAKPOINT);

  assign wfe_wake = wake.exc_take || (ctrl_r[SHBX_CTRL_SONP_BIT] && wake.exc_pend_new) ||
                    (ctrl_r[SHBX_CTRL_DBGEN_BIT] && wake.dbg_req) || wake.ext_event;
  assign wfi_wake = wake.exc_take || wake.dbg_req;

  // Sequencing of stalling instructions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SHBX_ST_IDLE: begin
        if (fire) begin
          unique case (instr.op)
            SHBX_OP_DSB: state_nxt = SHBX_ST_DSB_WAIT;
            SHBX_OP_ISB: state_nxt = SHBX_ST_ISB_FLUSH;
            SHBX_OP_WAIT_EVENT: state_nxt = event_r ? SHBX_ST_IDLE : SHBX_ST_WFE_SLEEP;
            SHBX_OP_WAIT_INTERRUPT: state_nxt = SHBX_ST_WFI_SLEEP;
            default: state_nxt = SHBX_ST_IDLE;
          endcase
        end
      end
      SHBX_ST_DSB_WAIT: if (mem_idle) state_nxt = SHBX_ST_IDLE;
      SHBX_ST_ISB_FLUSH: state_nxt = SHBX_ST_IDLE;
      SHBX_ST_WFE_SLEEP: if (wfe_wake) state_nxt = SHBX_ST_IDLE;
      SHBX_ST_WFI_SLEEP: if (wfi_wake) state_nxt = SHBX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SHBX_ST_IDLE;
      instr_ready <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Stalling in the cycle after the barrier keeps later instructions out
      instr_ready <= (state_nxt == SHBX_ST_IDLE);
      sleeping <= (state_nxt == SHBX_ST_WFE_SLEEP) || (state_nxt == SHBX_ST_WFI_SLEEP);
    end
  end

  // Memory barrier holds only the memory port, so other instructions flow on
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_hold <= 1'b0;
    end else if (fire && instr.op == SHBX_OP_DMB) begin
      mem_hold <= 1'b1;
    end else if (mem_idle) begin
      mem_hold <= 1'b0;
    end
  end

  // One-cycle requests to debug, exception and event logic
  always_ff @(posedge clk) begin
    if (rst) begin
      debug_enter <= 1'b0;
      svc_raise <= 1'b0;
      sev_out <= 1'b0;
      pipe_flush <= 1'b0;
    end else begin
      debug_enter <= fire && instr.op == SHBX_OP_BREAKPOINT;
      svc_raise <= fire && instr.op == SHBX_OP_SUPERVISOR_CALL;
      sev_out <= fire && instr.op == SHBX_OP_SEND_EVENT;
      pipe_flush <= state_r == SHBX_ST_ISB_FLUSH;
    end
  end

  // Local event register: a set in the same cycle as a wait-event clear wins
  always_ff @(posedge clk) begin
    if (rst) begin
      event_r <= 1'b0;
    end else if ((fire && instr.op == SHBX_OP_SEND_EVENT) || wake.ext_event) begin
      event_r <= 1'b1;
    end else if (fire && instr.op == SHBX_OP_WAIT_EVENT) begin
      event_r <= 1'b0;
    end else if (state_r == SHBX_ST_WFE_SLEEP && wfe_wake) begin
      event_r <= 1'b0;
    end
  end

  // Mask bits: change-state instruction and privileged special writes
  always_ff @(posedge clk) begin
    if (rst) begin
      interrupt_mask_bit <= 1'b0;
      fault_mask_bit <= 1'b0;
    end else if (fire && privileged) begin
      if (instr.op == SHBX_OP_MASK_SET || instr.op == SHBX_OP_MASK_CLEAR) begin
        if (instr.sel_int) interrupt_mask_bit <= instr.op == SHBX_OP_MASK_SET;
        if (instr.sel_fault) fault_mask_bit <= instr.op == SHBX_OP_MASK_SET;
      end else if (instr.op == SHBX_OP_TO_SPECIAL) begin
        if (instr.sr_sel == SHBX_SR_INT_MASK) interrupt_mask_bit <= instr.src[0];
        if (instr.sr_sel == SHBX_SR_FAULT_MASK) fault_mask_bit <= instr.src[0];
      end
    end
  end

  // Base priority, stack pointers and control: privileged writes only
  always_ff @(posedge clk) begin
    if (rst) begin
      base_priority_reg <= PRIO_W'(SHBX_BASE_PRIORITY_REG_RST);
      control <= SHBX_CONTROL_RST;
      main_sp <= SHBX_SP_RST;
      proc_sp <= SHBX_SP_RST;
    end else if (fire && privileged && instr.op == SHBX_OP_TO_SPECIAL) begin
      unique case (instr.sr_sel)
        SHBX_SR_BASE_PRIO: base_priority_reg <= instr.src[PRIO_W-1:0];
        SHBX_SR_BASE_PRIO_COND: begin
          if (instr.src[PRIO_W-1:0] != '0 &&
              (base_priority_reg == '0 || instr.src[PRIO_W-1:0] < base_priority_reg)) begin
            base_priority_reg <= instr.src[PRIO_W-1:0];
          end
        end
        SHBX_SR_CONTROL: control <= instr.src[1:0];
        SHBX_SR_MAIN_SP: main_sp <= instr.src & SHBX_SP_ALIGN;
        SHBX_SR_PROC_SP: proc_sp <= instr.src & SHBX_SP_ALIGN;
        default: ;
      endcase
    end
  end

  // Condition flags change only through a status write
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= SHBX_FLAGS_RST;
      flags_we <= 1'b0;
    end else begin
      flags_we <= 1'b0;
      if (fire && instr.op == SHBX_OP_TO_SPECIAL && has_app(instr.sr_sel)) begin
        // Only flag bits are stored, so exec and unallocated bits are dropped
        flags <= instr.src[SHBX_FLAGS_LSB +: SHBX_FLAGS_W];
        flags_we <= 1'b1;
      end
    end
  end

  // Special-to-general move; the read is privilege-free
  always_ff @(posedge clk) begin
    if (rst) begin
      gpr_we <= 1'b0;
      gpr_data <= '0;
    end else begin
      gpr_we <= fire && instr.op == SHBX_OP_TO_GENERAL;
      if (fire && instr.op == SHBX_OP_TO_GENERAL) begin
        gpr_data <= '0;
        if (is_status(instr.sr_sel)) begin
          if (has_app(instr.sr_sel)) gpr_data[SHBX_FLAGS_LSB +: SHBX_FLAGS_W] <= flags;
          if (instr.sr_sel inside {SHBX_SR_EXC, SHBX_SR_EXC_EXEC, SHBX_SR_EXC_APP, SHBX_SR_ALL}) begin
            gpr_data[SHBX_EXC_W-1:0] <= exc_num;
          end
          if (instr.sr_sel inside {SHBX_SR_EXEC, SHBX_SR_EXC_EXEC, SHBX_SR_EXEC_APP, SHBX_SR_ALL}) begin
            gpr_data[SHBX_EXEC_BIT] <= exec_state;
          end
        end else begin
          unique case (instr.sr_sel)
            SHBX_SR_MAIN_SP: gpr_data <= main_sp;
            SHBX_SR_PROC_SP: gpr_data <= proc_sp;
            SHBX_SR_INT_MASK: gpr_data <= {31'h0000_0000, interrupt_mask_bit};
            SHBX_SR_FAULT_MASK: gpr_data <= {31'h0000_0000, fault_mask_bit};
            SHBX_SR_BASE_PRIO,
            SHBX_SR_BASE_PRIO_COND: gpr_data <= 32'(base_priority_reg);
            SHBX_SR_CONTROL: gpr_data <= {30'h0000_0000, control};
            default: gpr_data <= '0;
          endcase
        end
      end
    end
  end

  // Control register: wake qualifiers for wait-event
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= SHBX_CTRL_RST;
    end else if (reg_wr && reg_addr == SHBX_OFF_CTRL) begin
      ctrl_r <= reg_wdata[SHBX_CTL_W-1:0];
    end
  end

  // Register read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr == SHBX_OFF_CTRL) begin
        reg_rdata[SHBX_CTL_W-1:0] <= ctrl_r;
      end else if (reg_addr == SHBX_OFF_STATUS) begin
        reg_rdata[SHBX_ST_BASE_PRIORITY_REG_LSB +: PRIO_W] <= base_priority_reg;
        reg_rdata[SHBX_ST_IMASK_BIT] <= interrupt_mask_bit;
        reg_rdata[SHBX_ST_FMASK_BIT] <= fault_mask_bit;
        reg_rdata[SHBX_ST_EVENT_BIT] <= event_r;
        reg_rdata[SHBX_ST_SLEEP_BIT] <= sleeping;
        reg_rdata[SHBX_ST_MHOLD_BIT] <= mem_hold;
        reg_rdata[SHBX_ST_STATE_LSB +: 3] <= state_r;
      end
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule // shbx_core
`default_nettype wire

// >>> design/shbx_pkg.sv
// Package for the system hint and barrier execution block.
// Assumes a single core clock domain and a decoded instruction stream.
`default_nettype none
package shbx_pkg;
  localparam int unsigned SHBX_DATA_W = 32;
  localparam int unsigned SHBX_PRIO_W = 8;
  localparam int unsigned SHBX_FLAGS_W = 5;
  localparam int unsigned SHBX_FLAGS_LSB = 27;
  localparam int unsigned SHBX_EXC_W = 9;
  localparam int unsigned SHBX_EXEC_BIT = 24;
  localparam int unsigned SHBX_CTL_W = 2;
  localparam int unsigned SHBX_ADDR_W = 4;

  // Register port offsets
  localparam logic [3:0] SHBX_OFF_CTRL = 4'h0;
  localparam logic [3:0] SHBX_OFF_STATUS = 4'h4;

  // Control register fields
  localparam int unsigned SHBX_CTRL_SONP_BIT = 0;
  localparam int unsigned SHBX_CTRL_DBGEN_BIT = 1;
  localparam logic [1:0] SHBX_CTRL_RST = 2'h0;

  // Status register fields
  localparam int unsigned SHBX_ST_BASE_PRIORITY_REG_LSB = 0;
  localparam int unsigned SHBX_ST_IMASK_BIT = 8;
  localparam int unsigned SHBX_ST_FMASK_BIT = 9;
  localparam int unsigned SHBX_ST_EVENT_BIT = 10;
  localparam int unsigned SHBX_ST_SLEEP_BIT = 11;
  localparam int unsigned SHBX_ST_MHOLD_BIT = 12;
  localparam int unsigned SHBX_ST_STATE_LSB = 16;

  // Reset values of the special registers
  localparam logic [31:0] SHBX_SP_RST = 32'h0000_0000;
  localparam logic [7:0] SHBX_BASE_PRIORITY_REG_RST = 8'h00;
  localparam logic [4:0] SHBX_FLAGS_RST = 5'h00;
  localparam logic [1:0] SHBX_CONTROL_RST = 2'h0;
  localparam logic [31:0] SHBX_SP_ALIGN = 32'hFFFF_FFFC;

  typedef enum logic [3:0] {
    SHBX_OP_NONE,
    SHBX_OP_BREAKPOINT,
    SHBX_OP_MASK_SET,
    SHBX_OP_MASK_CLEAR,
    SHBX_OP_DMB,
    SHBX_OP_DSB,
    SHBX_OP_ISB,
    SHBX_OP_TO_GENERAL,
    SHBX_OP_TO_SPECIAL,
    SHBX_OP_NOP,
    SHBX_OP_SEND_EVENT,
    SHBX_OP_SUPERVISOR_CALL,
    SHBX_OP_WAIT_EVENT,
    SHBX_OP_WAIT_INTERRUPT
  } shbx_op_t;

  typedef enum logic [3:0] {
    SHBX_SR_APP,
    SHBX_SR_EXC,
    SHBX_SR_EXEC,
    SHBX_SR_EXC_EXEC,
    SHBX_SR_EXC_APP,
    SHBX_SR_EXEC_APP,
    SHBX_SR_ALL,
    SHBX_SR_MAIN_SP,
    SHBX_SR_PROC_SP,
    SHBX_SR_INT_MASK,
    SHBX_SR_BASE_PRIO,
    SHBX_SR_BASE_PRIO_COND,
    SHBX_SR_FAULT_MASK,
    SHBX_SR_CONTROL
  } shbx_sr_sel_t;

  typedef enum logic [2:0] {
    SHBX_ST_IDLE,
    SHBX_ST_DSB_WAIT,
    SHBX_ST_ISB_FLUSH,
    SHBX_ST_WFE_SLEEP,
    SHBX_ST_WFI_SLEEP
  } shbx_state_t;

  typedef struct packed {
    logic valid;
    shbx_op_t op;
    logic cond_pass;
    logic sel_int;
    logic sel_fault;
    shbx_sr_sel_t sr_sel;
    logic [31:0] src;
    logic [7:0] imm;
  } shbx_instr_t;

  typedef struct packed {
    logic exc_take;
    logic exc_pend_new;
    logic dbg_req;
    logic ext_event;
  } shbx_wake_t;
endpackage : shbx_pkg
`default_nettype wire

// >>> testbench/shbx_core_props.sv
// Port checker for the system hint and barrier block.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module shbx_core_chk (
  input wire logic clk,
  input wire logic rst,
  input wire shbx_pkg::shbx_instr_t instr,
  input wire logic privileged,
  input wire logic mem_idle,
  input wire shbx_pkg::shbx_wake_t wake,
  input wire logic instr_ready,
  input wire logic flags_we,
  input wire logic [4:0] flags,
  input wire logic debug_enter,
  input wire logic pipe_flush,
  input wire logic mem_hold,
  input wire logic sleeping,
  input wire logic interrupt_mask_bit,
  input wire logic fault_mask_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  import shbx_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  wire logic tk = instr.valid && instr_ready;
  wire logic run = tk && instr.cond_pass;
  logic [4:0] src_fl_r;
  always_ff @(posedge clk) src_fl_r <= instr.src[31:27];

  brk_debug_a: assert property (tk && instr.op == SHBX_OP_BREAKPOINT |=> debug_enter)
    else $error("breakpoint without debug entry");
  cps_unpriv_a: assert property (tk && !privileged && instr.op inside {SHBX_OP_MASK_SET, SHBX_OP_MASK_CLEAR}
    |=> $stable(interrupt_mask_bit) && $stable(fault_mask_bit)) else $error("unprivileged mask change");
  dmb_hold_a: assert property (run && instr.op == SHBX_OP_DMB |=> mem_hold && instr_ready)
    else $error("memory barrier hold or stall wrong");
  hold_release_a: assert property (mem_hold && mem_idle && !(run && instr.op == SHBX_OP_DMB) |=> !mem_hold)
    else $error("memory hold not released");
  dsb_stall_a: assert property (run && instr.op == SHBX_OP_DSB |=> !instr_ready ##1 ($past(mem_idle) || !instr_ready))
    else $error("sync barrier did not stall");
  isb_flush_a: assert property (run && instr.op == SHBX_OP_ISB |=> !instr_ready ##1 (pipe_flush && instr_ready))
    else $error("instruction barrier flush wrong");
  msr_flags_a: assert property (run && instr.op == SHBX_OP_TO_SPECIAL &&
    instr.sr_sel inside {SHBX_SR_APP, SHBX_SR_EXC_APP, SHBX_SR_EXEC_APP, SHBX_SR_ALL}
    |=> flags_we && flags == src_fl_r) else $error("status write flags wrong");
  sleep_wake_a: assert property (sleeping && wake.exc_take |=> !sleeping)
    else $error("exception did not wake");

  cover property (run && instr.op == SHBX_OP_DSB);
  cover property (sleeping && wake.exc_take);
  cover property (pipe_flush);
endmodule // shbx_core_chk

bind shbx_core shbx_core_chk u_chk (.clk(clk), .rst(rst), .instr(instr), .privileged(privileged),
  .mem_idle(mem_idle), .wake(wake), .instr_ready(instr_ready), .flags_we(flags_we), .flags(flags),
  .debug_enter(debug_enter), .pipe_flush(pipe_flush), .mem_hold(mem_hold), .sleeping(sleeping),
  .interrupt_mask_bit(interrupt_mask_bit), .fault_mask_bit(fault_mask_bit));
`default_nettype wire

// >>> testbench/shbx_mem_model.sv
// Memory-system stand-in that reports outstanding accesses.
// Assumes the bench holds go high while earlier accesses are in flight.
`default_nettype none
module shbx_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic [3:0] len,
  output logic mem_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  always_ff @(posedge clk) begin
    if (rst) cnt_r <= 4'h0;
    else if (go) cnt_r <= len;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  // Idle only once the backlog drains, so barriers see a real wait
  assign mem_idle = (cnt_r == 4'h0);
endmodule // shbx_mem_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the system hint and barrier block.
// Assumes the bench plays the pipeline and the memory model reports idle.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import shbx_pkg::*;
  logic clk, rst, privileged, mem_idle, reg_wr, reg_rd, busy_go, instr_ready, gpr_we, flags_we;
  logic debug_enter, svc_raise, sev_out, pipe_flush, mem_hold, sleeping, imask, fmask;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, gpr_data, d, v;
  logic [4:0] flags;
  logic [7:0] bprio;
  logic [7:0] cw_src [4] = '{8'h00, 8'h60, 8'h70, 8'h20};
  logic [7:0] cw_exp [4] = '{8'h00, 8'h60, 8'h60, 8'h20};
  shbx_instr_t instr;
  shbx_wake_t wake;
  int seed, fails, cmp_count;

  shbx_mem_model mem (.clk(clk), .rst(rst), .go(busy_go), .len(4'h3), .mem_idle(mem_idle));
  shbx_core #(.PRIO_W(8)) dut (.clk(clk), .rst(rst), .instr(instr), .privileged(privileged), .exc_num(9'h000),
    .exec_state(1'b0), .mem_idle(mem_idle), .wake(wake), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_ready(instr_ready), .gpr_we(gpr_we),
    .gpr_data(gpr_data), .flags_we(flags_we), .flags(flags), .debug_enter(debug_enter), .svc_raise(svc_raise),
    .sev_out(sev_out), .pipe_flush(pipe_flush), .mem_hold(mem_hold), .sleeping(sleeping),
    .interrupt_mask_bit(imask), .fault_mask_bit(fmask), .base_priority_reg(bprio), .control(), .main_sp(),
    .proc_sp());

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Operand is a value, never a stack or program counter register number; mask flags ride in src[1:0]
  task automatic issue(input shbx_op_t op, input logic pv, input logic cp, input shbx_sr_sel_t sr, input logic [31:0] s);
    #1;
    repeat (50) if (instr_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    privileged <= pv;
    instr <= '{valid: 1'b1, op: op, cond_pass: cp, sel_int: s[0], sel_fault: s[1], sr_sel: sr, src: s,
      imm: 8'($random(seed))};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
  endtask

  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic pulse(input shbx_wake_t w);
    @(posedge clk);
    wake <= w;
    @(posedge clk);
    wake <= '0;
    #1;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    #100000;
    fails++;
    finish_test();
  end

  initial begin
    seed = 5312;
    rst = 1'b1;
    {privileged, reg_wr, reg_rd, busy_go} = 4'h0;
    instr = '0;
    wake = '0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, SHBX_OFF_STATUS, 32'h0);
    chk(d, 32'h0, "status after reset");
    acc(1'b0, 4'h8, 32'h0);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");

    issue(SHBX_OP_MASK_SET, 1'b1, 1'b1, SHBX_SR_APP, 32'h3);
    chk(32'({imask, fmask}), 32'h3, "mask set");
    issue(SHBX_OP_MASK_CLEAR, 1'b0, 1'b1, SHBX_SR_APP, 32'h3);
    chk(32'({imask, fmask}), 32'h3, "unprivileged clear");
    issue(SHBX_OP_MASK_CLEAR, 1'b1, 1'b1, SHBX_SR_APP, 32'h1);
    chk(32'({imask, fmask}), 32'h1, "interrupt mask clear");
    issue(SHBX_OP_MASK_CLEAR, 1'b1, 1'b1, SHBX_SR_APP, 32'h2);
    issue(SHBX_OP_BREAKPOINT, 1'b0, 1'b0, SHBX_SR_APP, 32'h0);
    chk(32'(debug_enter), 32'h1, "breakpoint, failed condition");
    issue(SHBX_OP_SUPERVISOR_CALL, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
    chk(32'(svc_raise), 32'h1, "supervisor call");
    issue(SHBX_OP_NOP, 1'b0, 1'b1, SHBX_SR_APP, $random(seed));
    chk(32'({flags_we, gpr_we, svc_raise}), 32'h0, "no-op effects");
    issue(SHBX_OP_SEND_EVENT, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
    chk(32'({sev_out, flags_we}), 32'h2, "send event");
    acc(1'b0, SHBX_OFF_STATUS, 32'h0);
    chk(d, 32'h400, "event set");
    issue(SHBX_OP_WAIT_EVENT, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
    chk(32'(sleeping), 32'h0, "wait with event set");
    acc(1'b0, SHBX_OFF_STATUS, 32'h0);
    chk(d, 32'h0, "event cleared");
    acc(1'b1, SHBX_OFF_CTRL, 32'h3);
    acc(1'b0, SHBX_OFF_CTRL, 32'h0);
    chk(d, 32'h3, "control readback");
    for (int i = 3; i >= 0; i--) begin
      issue(SHBX_OP_WAIT_EVENT, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
      chk(32'(sleeping), 32'h1, "wait event sleeps");
      pulse(shbx_wake_t'(4'h1 << i));
      chk(32'(sleeping), 32'h0, "wait event woken");
    end
    acc(1'b1, SHBX_OFF_CTRL, 32'h0);
    issue(SHBX_OP_WAIT_INTERRUPT, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
    pulse(shbx_wake_t'(4'h1));
    chk(32'(sleeping), 32'h1, "external event ignored");
    pulse(shbx_wake_t'(4'h2));
    chk(32'(sleeping), 32'h0, "debug request wakes");
    $display("test hints done");

    v = $random(seed);
    issue(SHBX_OP_TO_SPECIAL, 1'b0, 1'b1, SHBX_SR_ALL, v);
    chk(32'({flags_we, flags}), {26'h0, 1'b1, v[31:27]}, "status write");
    issue(SHBX_OP_TO_SPECIAL, 1'b0, 1'b1, SHBX_SR_BASE_PRIO, 32'h40);
    chk(32'(bprio), 32'h0, "unprivileged priority write");
    for (int i = 0; i < 4; i++) begin
      issue(SHBX_OP_TO_SPECIAL, 1'b1, 1'b1, SHBX_SR_BASE_PRIO_COND, 32'(cw_src[i]));
      chk(32'(bprio), 32'(cw_exp[i]), "conditional priority write");
    end
    issue(SHBX_OP_TO_GENERAL, 1'b1, 1'b1, SHBX_SR_BASE_PRIO_COND, 32'h0);
    chk(gpr_data, 32'h20, "conditional priority read");
    chk(32'({gpr_we, flags_we}), 32'h2, "read strobes");
    $display("test moves done");

    for (int i = 0; i < 2; i++) begin
      @(posedge clk) busy_go <= 1'b1;
      issue(i ? SHBX_OP_DSB : SHBX_OP_DMB, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
      chk(32'({mem_hold && i == 0, instr_ready}), i ? 32'h0 : 32'h3, "barrier taken");
      @(posedge clk) busy_go <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(32'({mem_hold && i == 0, instr_ready}), i ? 32'h0 : 32'h3, "barrier busy");
      @(posedge clk);
      #1 chk(32'({mem_hold, instr_ready}), 32'h1, "barrier released");
    end
    issue(SHBX_OP_ISB, 1'b0, 1'b1, SHBX_SR_APP, 32'h0);
    chk(32'({pipe_flush, instr_ready}), 32'h0, "flush pending");
    @(posedge clk);
    #1 chk(32'({pipe_flush, instr_ready}), 32'h3, "pipeline flushed");
    $display("test barriers done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
